// ===== counter_reg_mem.v
// Purpose: internal counter register words behind the data pointer
// Assumes: entry = counter*3 + {0 mode, 1 load, 2 hold}
// Notes:   read data come from a register; writes bypass to it
`timescale 1ns/1ns
`include "timer_cmd_regs.vh"

module counter_reg_mem (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        clear,
    input  wire        we,
    input  wire [3:0]  waddr,
    input  wire [15:0] wdata,
    input  wire [3:0]  raddr,
    output reg  [15:0] rdata_reg
);

    wire [255:0] flat;
    wire [255:0] init_flat;

    // ****************************************************************
    // storage, one word per entry
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : entry
            localparam [15:0] INIT =
                ((i % `REGS_PER_COUNTER) == 0 &&
                 i < `NUM_COUNTERS * `REGS_PER_COUNTER) ?
                `CMODE_RESET : `LOADHOLD_RESET;
            localparam integer IDX = i;
            reg [15:0] word_reg;
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    word_reg <= INIT;
                end else if (clear) begin
                    word_reg <= INIT;
                end else if (we && waddr == IDX[3:0]) begin
                    word_reg <= wdata;
                end
            end
            assign flat[i*16 +: 16]      = word_reg;
            assign init_flat[i*16 +: 16] = INIT;
        end
    endgenerate

    // ****************************************************************
    // registered read port
    // ****************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= `CMODE_RESET;
        end else if (clear) begin
            rdata_reg <= init_flat[{raddr, 4'h0} +: 16];
        end else if (we && waddr == raddr) begin
            rdata_reg <= wdata;
        end else begin
            rdata_reg <= flat[{raddr, 4'h0} +: 16];
        end
    end

endmodule // counter_reg_mem

// ===== host_bus_model.sv
// Purpose: host processor on the register port
// Assumes: one-cycle strobes, read data in the following cycle
// Notes:   write data inverted when the bus is released
`timescale 1ns/1ns
module host_bus_model (
    input  wire         clk,
    input  wire  [15:0] rdata,
    output logic [1:0]  addr,
    output logic [15:0] wdata,
    output logic        wr_strobe,
    output logic        rd_strobe
);
    initial begin
        addr = 2'h0;
        wdata = 16'h0000;
        wr_strobe = 1'b0;
        rd_strobe = 1'b0;
    end
    task wr(input [1:0] a, input [15:0] d);
        @(posedge clk);
        wr_strobe <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_strobe <= 1'b0;
        wdata <= ~d;
    endtask
    task rd(input [1:0] a, output [15:0] d);
        @(posedge clk);
        rd_strobe <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_strobe <= 1'b0;
        #1 d = rdata;
    endtask
endmodule // host_bus_model

// ===== testbench.sv
// Purpose: self-checking bench for the command interpreter
// Assumes: host_bus_model drives the register port
// Notes:   model state kept in plain variables
`timescale 1ns/1ns
`include "timer_cmd_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module testbench;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    wire  [1:0]  addr;
    wire  [15:0] wdata, rdata, master_mode;
    wire         wr_strobe, rd_strobe, write_prefetch_off, freq_out_pin;
    wire  [4:0]  counter_armed;
    int          fails = 0;
    int          n_compared = 0;
    int          i, k;
    logic [15:0] mm, lo, seed, v, e;
    logic [15:0] mem [0:15];
    logic [7:0]  codes [0:7];
    logic [4:0]  arm;
    logic [3:0]  ptr;
    logic        wpf, bp;
    always #5 clk = ~clk;
    host_bus_model host (.clk(clk), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe));
    timer_master_mode_commands DUT (.clk(clk), .rst_b(rst_b), .addr(addr),
        .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .rdata(rdata), .master_mode(master_mode),
        .counter_armed(counter_armed),
        .write_prefetch_off(write_prefetch_off),
        .freq_out_pin(freq_out_pin));
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task clr;
        mm = 16'h0000;
        arm = 5'h00;
        wpf = 1'b0;
        for (k = 0; k < 16; k++)
            mem[k] = (k % 3 == 0 && k < 15) ? `CMODE_RESET : 16'h0000;
    endtask
    task adv;
        if (!mm[14]) ptr = (ptr == `PTR_LAST) ? 4'h0 : ptr + 4'h1;
    endtask
    task bw(input [1:0] a, input [15:0] d);
        host.wr(a, d);
        if (a == `OFS_CMD) begin
            case (d[7:0])
                `CMD_SEQ_ON:   mm[14] = 1'b0;
                `CMD_SEQ_OFF:  mm[14] = 1'b1;
                `CMD_BUS_16:   mm[13] = 1'b1;
                `CMD_BUS_8:    mm[13] = 1'b0;
                `CMD_FREQ_OUT_PIN_OFF: mm[12] = 1'b1;
                `CMD_FREQ_OUT_PIN_ON:  mm[12] = 1'b0;
                `CMD_WPF_OFF:  wpf = 1'b1;
                `CMD_WPF_ON:   wpf = 1'b0;
                `CMD_RESET:    clr;
                default:
                    if ((d[7:0] & `CMD_ARM_MASK) == `CMD_ARM_CODE)
                        arm |= d[4:0];
            endcase
        end else if (a == `OFS_MASTER_MODE) mm = d;
        else if (a == `OFS_POINTER) begin
            ptr = d[3:0];
            bp = 1'b0;
        end else if (mm[13]) begin
            mem[ptr] = d;
            bp = 1'b0;
            adv;
        end else if (!bp) begin
            lo = d;
            bp = 1'b1;
        end else begin
            mem[ptr] = {d[7:0], lo[7:0]};
            bp = 1'b0;
            adv;
        end
        #1;
        `CHK(master_mode, mm)
        `CHK(write_prefetch_off, wpf)
        `CHK(counter_armed, arm)
    endtask
    task br(input [1:0] a);
        host.rd(a, v);
        if (a == `OFS_CMD) e = {9'h000, arm, wpf, bp};
        else if (a == `OFS_MASTER_MODE) e = mm;
        else if (a == `OFS_POINTER) e = {12'h000, ptr};
        else if (mm[13]) begin
            e = mem[ptr];
            bp = 1'b0;
            adv;
        end else begin
            e = {8'h00, bp ? mem[ptr][15:8] : mem[ptr][7:0]};
            if (bp) adv;
            bp = ~bp;
        end
        `CHK(v, e)
    endtask
    task init(input [3:0] p);
        bw(`OFS_CMD, {8'h00, `CMD_RESET});
        bw(`OFS_CMD, {8'h00, `CMD_LOAD_ALL});
        bw(`OFS_POINTER, {12'h000, p});
    endtask
    task test_done;
        if (fails == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        test_done;
    end
    initial begin
        codes = '{8'hE0, 8'hE8, 8'hEF, 8'hE7, 8'hEE, 8'hE6, 8'hF9, 8'hF8};
        seed = 16'hDA5C;
        clr;
        ptr = 4'h0;
        bp = 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 `CHK(master_mode, `MM_RESET)
        init(4'h0);
        bw(`OFS_CMD, 16'h00EF);
        for (i = 0; i < 16; i++) br(`OFS_DATA);
        bw(`OFS_CMD, 16'h00E8);
        repeat (3) br(`OFS_DATA);
        bw(`OFS_CMD, 16'h00E0);
        for (i = 0; i < 15; i++) begin
            seed = lfsr(seed);
            bw(`OFS_DATA, seed);
        end
        bw(`OFS_POINTER, 16'h0000);
        for (i = 0; i < 15; i++) br(`OFS_DATA);
        bw(`OFS_CMD, 16'h00E7);
        bw(`OFS_POINTER, 16'h0005);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            bw(`OFS_DATA, seed);
        end
        bw(`OFS_POINTER, 16'h0005);
        for (i = 0; i < 6; i++) br(`OFS_DATA);
        for (i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            bw(`OFS_MASTER_MODE, seed);
            for (k = 0; k < 8; k++) bw(`OFS_CMD, {8'h00, codes[k]});
            br(`OFS_MASTER_MODE);
        end
        bw(`OFS_MASTER_MODE, 16'h0300);
        bw(`OFS_CMD, 16'h00EE);
        repeat (2) @(posedge clk);
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            `CHK(freq_out_pin, 1'b0)
        end
        bw(`OFS_CMD, 16'h00E6);
        @(posedge clk);
        k = 0;
        // divide by three: three high samples in every six
        for (i = 0; i < 60; i++) begin
            @(posedge clk);
            if (freq_out_pin === 1'b1) k++;
        end
        `CHK(k, 30)
        bw(`OFS_CMD, 16'h00F9);
        bw(`OFS_CMD, 16'h003F);
        bw(`OFS_DATA, 16'h1234);
        br(`OFS_CMD);
        bw(`OFS_CMD, 16'h00F8);
        bw(`OFS_CMD, 16'h00F9);
        init(4'h3);
        br(`OFS_POINTER);
        br(`OFS_CMD);
        br(`OFS_DATA);
        br(`OFS_DATA);
        test_done;
    end
endmodule // testbench

// ===== timer_cmd_checker.sv
// Purpose: port checker for the master-mode command interpreter
// Assumes: design constants from timer_cmd_regs.vh
// Notes:   outputs settle one edge after the command write, freq_out_pin one edge later
`timescale 1ns/1ns
`include "timer_cmd_regs.vh"
module timer_cmd_checker (
    input wire        clk,
    input wire        rst_b,
    input wire [1:0]  addr,
    input wire [15:0] wdata,
    input wire        wr_strobe,
    input wire        rd_strobe,
    input wire [15:0] rdata,
    input wire [15:0] master_mode,
    input wire [4:0]  counter_armed,
    input wire        write_prefetch_off,
    input wire        freq_out_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // bits a bit command may not touch; all ones for other codes
    function automatic logic [15:0] keep_mask(logic [7:0] c);
        case (c)
            `CMD_SEQ_ON, `CMD_SEQ_OFF:   keep_mask = 16'hBFFF;
            `CMD_BUS_16, `CMD_BUS_8:     keep_mask = 16'hDFFF;
            `CMD_FREQ_OUT_PIN_OFF, `CMD_FREQ_OUT_PIN_ON: keep_mask = 16'hEFFF;
            default:                     keep_mask = 16'hFFFF;
        endcase
    endfunction
    sequence s_cmd(logic [7:0] c);
        wr_strobe && addr == `OFS_CMD && wdata[7:0] == c;
    endsequence
    sequence s_bit_cmd;
        wr_strobe && addr == `OFS_CMD && keep_mask(wdata[7:0]) != 16'hFFFF;
    endsequence
    sequence s_mm_load;
        wr_strobe && addr == `OFS_MASTER_MODE;
    endsequence
    a_seq_on: assert property (
        s_cmd(`CMD_SEQ_ON) |=> !master_mode[`MM_SEQ_OFF_BIT])
        else $error("sequence enable did not clear bit 14");
    a_seq_off: assert property (
        s_cmd(`CMD_SEQ_OFF) |=> master_mode[`MM_SEQ_OFF_BIT])
        else $error("sequence disable did not set bit 14");
    a_bus_wide: assert property (
        s_cmd(`CMD_BUS_16) |=> master_mode[`MM_WIDE_BIT])
        else $error("wide bus command did not set bit 13");
    a_bus_narrow: assert property (
        s_cmd(`CMD_BUS_8) |=> !master_mode[`MM_WIDE_BIT])
        else $error("narrow bus command did not clear bit 13");
    a_gate_off: assert property (
        s_cmd(`CMD_FREQ_OUT_PIN_OFF) |=> master_mode[`MM_GATE_OFF_BIT]
            ##1 !freq_out_pin)
        else $error("gate off did not silence the frequency pin");
    a_gate_low: assert property (
        $past(master_mode[`MM_GATE_OFF_BIT]) |-> !freq_out_pin)
        else $error("frequency pin active while gated off");
    a_gate_on: assert property (
        s_cmd(`CMD_FREQ_OUT_PIN_ON) |=> !master_mode[`MM_GATE_OFF_BIT])
        else $error("gate on did not clear bit 12");
    a_bits_kept: assert property (
        s_bit_cmd |=> ((master_mode ^ $past(master_mode)) &
            keep_mask($past(wdata[7:0]))) == 16'h0000)
        else $error("bit command disturbed other bits");
    a_word_load: assert property (
        s_mm_load |=> master_mode == $past(wdata))
        else $error("full word load not taken");
    a_wpf_set: assert property (
        s_cmd(`CMD_WPF_OFF) |=> write_prefetch_off)
        else $error("write prefetch not disabled");
    a_wpf_hold: assert property (
        !(wr_strobe && addr == `OFS_CMD) |=> $stable(write_prefetch_off))
        else $error("write prefetch flag changed without command");
    a_wpf_clear: assert property (
        s_cmd(`CMD_WPF_ON) |=> !write_prefetch_off
            && $stable(master_mode) && $stable(counter_armed))
        else $error("prefetch enable wrong or had side effects");
    a_soft_reset: assert property (
        s_cmd(`CMD_RESET) |=> master_mode == `MM_RESET
            && counter_armed == 5'h00 && !write_prefetch_off)
        else $error("master reset incomplete");
endmodule // timer_cmd_checker
bind timer_master_mode_commands timer_cmd_checker u_chk (.clk(clk),
    .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .master_mode(master_mode),
    .counter_armed(counter_armed), .write_prefetch_off(write_prefetch_off),
    .freq_out_pin(freq_out_pin));

// ===== timer_cmd_regs.vh
// Purpose: constants for the master-mode command interpreter
// Assumes: 16-bit register port, 100 MHz clock
// Notes:   offsets are register-port addresses, not byte addresses
`ifndef TIMER_CMD_REGS_VH
`define TIMER_CMD_REGS_VH

// ****************************************************************
// register port offsets
// ****************************************************************
`define OFS_DATA          2'h0
`define OFS_CMD           2'h1
`define OFS_MASTER_MODE   2'h2
`define OFS_POINTER       2'h3

// ****************************************************************
// command codes
// ****************************************************************
`define CMD_SEQ_ON        8'hE0
`define CMD_SEQ_OFF       8'hE8
`define CMD_BUS_16        8'hEF
`define CMD_BUS_8         8'hE7
`define CMD_FREQ_OUT_PIN_OFF      8'hEE
`define CMD_FREQ_OUT_PIN_ON       8'hE6
`define CMD_WPF_OFF       8'hF9
`define CMD_WPF_ON        8'hF8
`define CMD_RESET         8'hFF
`define CMD_LOAD_ALL      8'h5F
`define CMD_ARM_MASK      8'hE0
`define CMD_ARM_CODE      8'h20

// ****************************************************************
// master mode fields
// ****************************************************************
`define MM_SEQ_OFF_BIT    14
`define MM_WIDE_BIT       13
`define MM_GATE_OFF_BIT   12
`define MM_DIV_HI         11
`define MM_DIV_LO         8

// ****************************************************************
// status word fields
// ****************************************************************
`define ST_BYTE_PTR_BIT   0
`define ST_WPF_OFF_BIT    1
`define ST_ARMED_LO       2
`define ST_ARMED_HI       6

// ****************************************************************
// reset values and sizes
// ****************************************************************
`define MM_RESET          16'h0000
`define CMODE_RESET       16'h0800
`define LOADHOLD_RESET    16'h0000
`define PTR_RESET         4'h0
`define PTR_LAST          4'hE
`define NUM_COUNTERS      5
`define REGS_PER_COUNTER  3

`endif

// ===== timer_master_mode_commands.v
// Purpose: command interpreter for master-mode bits, prefetch control
//          and software master reset of a five-counter timer
// Assumes: register port strobes synchronous to clk, one cycle long
// Notes:   the internal words are read through a prefetch register
//          the pointer comes out of reset at zero, but software is
//          expected to load it before touching the data offset
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
`include "timer_cmd_regs.vh"

module timer_master_mode_commands (
    input  wire        clk,
    input  wire        rst_b,
    input  wire [1:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr_strobe,
    input  wire        rd_strobe,
    output reg  [15:0] rdata,
    output reg  [15:0] master_mode,
    output reg  [4:0]  counter_armed,
    output reg         write_prefetch_off,
    output reg         freq_out_pin
);

    // ****************************************************************
    // access decode
    // ****************************************************************
    wire        wr_cmd;
    wire        wr_mm;
    wire        wr_ptr;
    wire        wr_data;
    wire        rd_data;
    wire [7:0]  cmd;

    assign wr_cmd  = wr_strobe && (addr == `OFS_CMD);
    assign wr_mm   = wr_strobe && (addr == `OFS_MASTER_MODE);
    assign wr_ptr  = wr_strobe && (addr == `OFS_POINTER);
    assign wr_data = wr_strobe && (addr == `OFS_DATA);
    assign rd_data = rd_strobe && (addr == `OFS_DATA);
    assign cmd     = wdata[7:0];

    wire        is_reset_cmd;
    wire        is_arm_cmd;

    assign is_reset_cmd = wr_cmd && (cmd == `CMD_RESET);
    assign is_arm_cmd   = wr_cmd &&
                          ((cmd & `CMD_ARM_MASK) == `CMD_ARM_CODE);

    // ****************************************************************
    // master mode register
    // ****************************************************************
    reg  [15:0] mm_reg;
    reg  [15:0] mm_next;

    always @* begin
        mm_next = mm_reg;
        if (wr_mm) begin
            mm_next = wdata;
        end else if (wr_cmd) begin
            case (cmd)
                `CMD_SEQ_ON: begin
                    mm_next[`MM_SEQ_OFF_BIT] = 1'b0;
                end
                `CMD_SEQ_OFF: begin
                    mm_next[`MM_SEQ_OFF_BIT] = 1'b1;
                end
                `CMD_BUS_16: begin
                    mm_next[`MM_WIDE_BIT] = 1'b1;
                end
                `CMD_BUS_8: begin
                    mm_next[`MM_WIDE_BIT] = 1'b0;
                end
                `CMD_FREQ_OUT_PIN_OFF: begin
                    mm_next[`MM_GATE_OFF_BIT] = 1'b1;
                end
                `CMD_FREQ_OUT_PIN_ON: begin
                    mm_next[`MM_GATE_OFF_BIT] = 1'b0;
                end
                `CMD_RESET: begin
                    mm_next = `MM_RESET;
                end
                default: begin
                    mm_next = mm_reg;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mm_reg <= `MM_RESET;
        end else begin
            mm_reg <= mm_next;
        end
    end

    wire        seq_off;
    wire        wide;
    wire        gate_off;

    assign seq_off  = mm_reg[`MM_SEQ_OFF_BIT];
    assign wide     = mm_reg[`MM_WIDE_BIT];
    assign gate_off = mm_reg[`MM_GATE_OFF_BIT];

    // ****************************************************************
    // write prefetch control and counter arming
    // ****************************************************************
    reg         wpf_off_reg;
    reg         wpf_off_next;
    reg  [4:0]  armed_reg;
    reg  [4:0]  armed_next;

    // write prefetch has no data-path effect here; only the flag is kept
    always @* begin
        wpf_off_next = wpf_off_reg;
        if (wr_cmd) begin
            case (cmd)
                `CMD_WPF_OFF: begin
                    wpf_off_next = 1'b1;
                end
                `CMD_WPF_ON: begin
                    wpf_off_next = 1'b0;
                end
                `CMD_RESET: begin
                    wpf_off_next = 1'b0;
                end
                default: begin
                    wpf_off_next = wpf_off_reg;
                end
            endcase
        end
    end

    always @* begin
        armed_next = armed_reg;
        if (is_reset_cmd) begin
            armed_next = 5'h00;
        end else if (is_arm_cmd) begin
            armed_next = armed_reg | cmd[4:0];
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wpf_off_reg <= 1'b0;
            armed_reg   <= 5'h00;
        end else begin
            wpf_off_reg <= wpf_off_next;
            armed_reg   <= armed_next;
        end
    end

    // ****************************************************************
    // data pointer and byte pointer
    // ****************************************************************
    reg  [3:0]  ptr_reg;
    reg  [3:0]  ptr_next;
    reg         byte_ptr_reg;
    reg         byte_ptr_next;
    wire        data_access;
    wire        word_done;

    assign data_access = wr_data || rd_data;
    assign word_done   = data_access && (wide || byte_ptr_reg);

    always @* begin
        ptr_next      = ptr_reg;
        byte_ptr_next = byte_ptr_reg;
        if (wr_ptr) begin
            ptr_next      = wdata[3:0];
            byte_ptr_next = 1'b0;
        end else if (data_access) begin
            byte_ptr_next = wide ? 1'b0 : ~byte_ptr_reg;
            if (word_done && !seq_off) begin
                ptr_next = (ptr_reg == `PTR_LAST) ?
                           4'h0 : ptr_reg + 4'h1;
            end
        end
    end

    // the master reset leaves the pointer where it was
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_reg      <= `PTR_RESET;
            byte_ptr_reg <= 1'b0;
        end else begin
            ptr_reg      <= ptr_next;
            byte_ptr_reg <= byte_ptr_next;
        end
    end

    // ****************************************************************
    // word assembly for the eight-bit bus
    // ****************************************************************
    reg  [7:0]  low_byte_reg;
    wire        mem_we;
    wire [15:0] mem_wdata;
    wire [15:0] prefetch;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_byte_reg <= 8'h00;
        end else if (wr_data && !wide && !byte_ptr_reg) begin
            low_byte_reg <= wdata[7:0];
        end
    end

    assign mem_we    = wr_data && word_done;
    assign mem_wdata = wide ? wdata : {wdata[7:0], low_byte_reg};

    // prefetch follows the next pointer so back-to-back reads see
    // the word the pointer lands on
    counter_reg_mem u_mem (
        .clk       (clk),
        .rst_b     (rst_b),
        .clear     (is_reset_cmd),
        .we        (mem_we),
        .waddr     (ptr_reg),
        .wdata     (mem_wdata),
        .raddr     (ptr_next),
        .rdata_reg (prefetch)
    );

    // ****************************************************************
    // read data, valid only in the cycle after the strobe
    // ****************************************************************
    reg  [15:0] rdata_next;
    wire [15:0] status_word;

    assign status_word = {9'h000, armed_reg, wpf_off_reg, byte_ptr_reg};

    always @* begin
        rdata_next = 16'h0000;
        if (rd_strobe) begin
            case (addr)
                `OFS_DATA: begin
                    if (wide) begin
                        rdata_next = prefetch;
                    end else if (byte_ptr_reg) begin
                        rdata_next = {8'h00, prefetch[15:8]};
                    end else begin
                        rdata_next = {8'h00, prefetch[7:0]};
                    end
                end
                `OFS_CMD: begin
                    rdata_next = status_word;
                end
                `OFS_MASTER_MODE: begin
                    rdata_next = mm_reg;
                end
                `OFS_POINTER: begin
                    rdata_next = {12'h000, ptr_reg};
                end
                default: begin
                    rdata_next = 16'h0000;
                end
            endcase
        end
    end

    // ****************************************************************
    // frequency output divider and gate
    // ****************************************************************
    reg  [3:0]  div_cnt_reg;
    reg         freq_level_reg;
    wire [3:0]  div_last;
    wire        div_tick;

    // a divide field of zero means divide by sixteen
    assign div_last = mm_reg[`MM_DIV_HI:`MM_DIV_LO] - 4'h1;
    assign div_tick = (div_cnt_reg == div_last);

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg    <= 4'h0;
            freq_level_reg <= 1'b0;
        end else if (div_tick) begin
            div_cnt_reg    <= 4'h0;
            freq_level_reg <= ~freq_level_reg;
        end else begin
            div_cnt_reg    <= div_cnt_reg + 4'h1;
        end
    end

    // gating is not aligned to the divided clock, so a short pulse
    // may appear when the gate changes
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            freq_out_pin <= 1'b0;
        end else begin
            freq_out_pin <= gate_off ? 1'b0 : freq_level_reg;
        end
    end

    // ****************************************************************
    // output registers, loaded from the same next values as the
    // internal state so the ports never lag the command
    // ****************************************************************
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= rdata_next;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            master_mode <= `MM_RESET;
        end else begin
            master_mode <= mm_next;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            counter_armed <= 5'h00;
        end else begin
            counter_armed <= armed_next;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            write_prefetch_off <= 1'b0;
        end else begin
            write_prefetch_off <= wpf_off_next;
        end
    end

endmodule // timer_master_mode_commands
